// file: rtl/sbc_mode_cfg.svh
// Constants for the operating-mode and interrupt controller.
// Assumes a 200 MHz device clock.
`ifndef SBC_MODE_CFG_SVH
`define SBC_MODE_CFG_SVH

`define CLK_PERIOD_PS         5000
`define RESET_HOLD_US         1000
`define NORM_REQ_TIMEOUT_US   150000
`define RESET_HOLD_CYCLES     ((`RESET_HOLD_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define NORM_REQ_CYCLES       ((`NORM_REQ_TIMEOUT_US * 1000000) / `CLK_PERIOD_PS)
`define TIMER_W               25
`define MODE_SEL_NORMAL       2'h0
`define MODE_SEL_STOP         2'h1
`define MODE_SEL_SLEEP        2'h2
`define IRQ_SRC_W             8
`define IRQ_UNDERVOLT         0
`define IRQ_OVERVOLT          1
`define IRQ_TEMP_WARN         2
`define IRQ_BUS_OVERTEMP      3
`define IRQ_BUS_STUCK         4
`define IRQ_BUS_RX_SHORT      5
`define IRQ_HS_OVERTEMP       6
`define IRQ_LS_OVERTEMP       7
`define IRQ_BUS_MASK          8'h38

`endif

// file: rtl/sbc_mode_pkg.sv
// Types for the operating-mode and interrupt controller.
// Assumes sbc_mode_cfg.svh is on the include path.
`include "sbc_mode_cfg.svh"

package sbc_mode_pkg;

	typedef enum logic [2:0] {
		st_reset      = 3'h0,
		st_normal_req = 3'h1,
		st_normal     = 3'h2,
		st_stop       = 3'h3,
		st_sleep      = 3'h4
	} op_mode_t;

	typedef struct packed {
		logic       high_side_switch;
		logic       pwm_high_side;
		logic [1:0] low_side_switches;
		logic [1:0] pwm_low_side;
		logic       cyclic_sense;
	} switch_cfg_t;

	typedef struct packed {
		logic       high_side_switch;
		logic [1:0] low_side_switches;
		logic       analog_mux_enable;
		logic       wake_inputs_enable;
		logic       bus_tx_enable;
		logic       bus_rx_enable;
		logic       regulator_on;
		logic       regulator_full;
	} mode_outputs_t;

endpackage

// file: rtl/sbc_mode_and_irq_control.sv
// Operating-mode sequencer and interrupt line of the system basis chip.
// Assumes SPI decoding elsewhere: mode writes, status reads and source
// reads arrive as one-cycle pulses on clk; fault levels come from pins.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_mode_cfg.svh"

module sbc_mode_and_irq_control
	import sbc_mode_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset,
	// Pins from outside
	input  wire logic                    watchdog_config_grounded,
	input  wire logic                    watchdog_config_open,
	input  wire logic                    regulator_low,
	input  wire logic                    ext_reset_low,
	input  wire logic                    pwm_input_pin,
	input  wire logic                    chip_select_rise,
	input  wire logic                    wake_event,
	input  wire logic                    cyclic_tick,
	input  wire logic [`IRQ_SRC_W-1:0]   fault_level,
	// SPI side
	input  wire logic                    mode_write,
	input  wire logic [1:0]              mode_select_bits,
	input  wire logic                    timing_write,
	input  wire logic                    watchdog_fail,
	input  wire logic                    watchdog_clear_early,
	input  wire logic                    status_read,
	input  wire logic                    wake_source_read,
	input  wire logic [`IRQ_SRC_W-1:0]   interrupt_mask_reg,
	input  wire switch_cfg_t             switch_cfg,
	// Outputs
	output logic                         reset_out_low,
	output logic                         irq_low,
	output op_mode_t                     mode,
	output mode_outputs_t                outs,
	output logic [`IRQ_SRC_W-1:0]        interrupt_source_reg,
	output logic                         wake_pending,
	output logic                         battery_fail_flag,
	output logic                         bus_driver_enable
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, generated per bit
	localparam int SYNC_W = `IRQ_SRC_W + 8;
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	wire  [SYNC_W-1:0] raw_pins = {fault_level, watchdog_config_grounded,
		watchdog_config_open, regulator_low, ext_reset_low, pwm_input_pin,
		chip_select_rise, wake_event, cyclic_tick};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (reset) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= raw_pins[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	wire [`IRQ_SRC_W-1:0] faults = sync_b[SYNC_W-1:8];
	wire wd_grounded = sync_b[7];
	wire wd_open     = sync_b[6];
	wire reg_low     = sync_b[5];
	wire ext_rst     = sync_b[4];
	wire pwm_in      = sync_b[3];
	wire cs_rise     = sync_b[2];
	wire wake_in     = sync_b[1];
	wire cyc_tick    = sync_b[0];

	////////////////////////////////////////////////////////////////////////
	// Mode sequencer
	op_mode_t next_mode;
	logic [`TIMER_W-1:0] timer;
	logic [`TIMER_W-1:0] next_timer;
	logic wd_grounded_latched;
	logic from_sleep;

	wire hold_src = reg_low || ext_rst;
	wire normal_cmd = mode_write && (mode_select_bits == `MODE_SEL_NORMAL);
	wire stop_cmd   = mode_write && (mode_select_bits == `MODE_SEL_STOP);
	wire sleep_cmd  = mode_write && (mode_select_bits == `MODE_SEL_SLEEP);
	wire wd_bad     = watchdog_fail || watchdog_clear_early;
	wire hold_done  = (timer >= `TIMER_W'(`RESET_HOLD_CYCLES - 1));
	wire nreq_done  = (timer >= `TIMER_W'(`NORM_REQ_CYCLES - 1));
	wire stop_wake  = wake_in || cs_rise;
	wire wake_irq_ok = wake_in && !cs_rise;

	always_comb begin
		next_mode  = mode;
		next_timer = (timer == {`TIMER_W{1'b1}}) ? timer : timer + 1'b1;
		case (mode)
			st_reset: begin
				if (hold_src) begin
					next_timer = '0;
				end else if (hold_done) begin
					next_timer = '0;
					next_mode  = wd_grounded_latched ? st_normal
						: st_normal_req;
				end
			end
			st_normal_req: begin
				if (hold_src || wd_bad) begin
					next_mode = st_reset;
				end else if (normal_cmd && !wd_open) begin
					next_mode = st_normal;
				end else if (nreq_done) begin
					next_mode = wd_open ? st_normal : st_reset;
				end
			end
			st_normal: begin
				if (hold_src || wd_bad) begin
					next_mode = st_reset;
				end else if (sleep_cmd) begin
					next_mode = st_sleep;
				end else if (stop_cmd) begin
					next_mode = st_stop;
				end
			end
			st_stop: begin
				if (reg_low) begin
					next_mode = st_reset;
				end else if (stop_wake || ext_rst) begin
					next_mode = wd_grounded_latched ? st_normal
						: st_normal_req;
				end
			end
			st_sleep: begin
				if (wake_in) begin
					next_mode = st_reset;
				end
			end
			default: next_mode = st_reset;
		endcase
		if (next_mode != mode) begin
			next_timer = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mode   <= st_reset;
			timer  <= '0;
			from_sleep <= 1'b0;
		end else begin
			mode   <= next_mode;
			timer  <= next_timer;
			if (mode == st_sleep && next_mode == st_reset) begin
				from_sleep <= 1'b1;
			end else if (status_read) begin
				from_sleep <= 1'b0;
			end
		end
	end

	// Strap caught only in reset mode, after release
	always_ff @(posedge clk) begin
		if (reset) begin
			wd_grounded_latched <= 1'b0;
		end else if (mode == st_reset) begin
			wd_grounded_latched <= wd_grounded;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Function gating per mode
	wire in_run  = (mode == st_normal) || (mode == st_normal_req);
	wire low_pwr = (mode == st_stop) || (mode == st_sleep);
	// Outputs follow the mode being entered, so they switch with mode
	wire nm_run  = (next_mode == st_normal) || (next_mode == st_normal_req);
	wire nm_low  = (next_mode == st_stop) || (next_mode == st_sleep);
	wire hs_req  = switch_cfg.high_side_switch &&
		(!switch_cfg.pwm_high_side || pwm_in);
	wire [1:0] ls_req = switch_cfg.low_side_switches &
		(~switch_cfg.pwm_low_side | {2{pwm_in}});
	wire cyc_hs  = nm_low && switch_cfg.cyclic_sense && cyc_tick;
	logic bus_fault_hold;
	wire bus_fault_now = |(faults & `IRQ_BUS_MASK);

	mode_outputs_t next_outs;
	always_comb begin
		next_outs = '0;
		next_outs.high_side_switch  = (nm_run && hs_req) || cyc_hs;
		next_outs.low_side_switches = nm_run ? ls_req : 2'h0;
		next_outs.analog_mux_enable = nm_run;
		next_outs.wake_inputs_enable = nm_low;
		next_outs.bus_tx_enable = (next_mode == st_normal)
			&& !bus_fault_hold;
		next_outs.bus_rx_enable = (next_mode != st_reset);
		next_outs.regulator_on = (next_mode != st_sleep);
		next_outs.regulator_full = nm_run
			|| (next_mode == st_reset);
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt sources and line
	wire irq_allowed = (in_run || mode == st_stop) && !hold_src;
	wire [`IRQ_SRC_W-1:0] src_set = in_run ? (faults & ~interrupt_mask_reg)
		: '0;
	wire stop_wake_set = (mode == st_stop) && wake_irq_ok;
	// Sources held back by a pending wake still raise the line later
	wire irq_pending = (|src_set) || stop_wake_set
		|| ((|interrupt_source_reg) && !status_read);

	always_ff @(posedge clk) begin
		if (reset) begin
			interrupt_source_reg <= '0;
			wake_pending <= 1'b0;
			irq_low <= 1'b1;
			bus_fault_hold <= 1'b0;
		end else begin
			// Set wins over clear
			interrupt_source_reg <= src_set |
				(status_read ? '0 : interrupt_source_reg);
			wake_pending <= stop_wake_set ||
				(wake_pending && !wake_source_read);
			if (irq_allowed && irq_pending && !wake_pending) begin
				irq_low <= 1'b0;
			end else if (status_read || !irq_allowed) begin
				irq_low <= 1'b1;
			end
			if (bus_fault_now) begin
				bus_fault_hold <= 1'b1;
			end else if (status_read) begin
				bus_fault_hold <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			reset_out_low <= 1'b1;
			outs <= '0;
			battery_fail_flag <= 1'b1;
			bus_driver_enable <= 1'b0;
		end else begin
			reset_out_low <= (next_mode != st_reset);
			outs <= next_outs;
			bus_driver_enable <= next_outs.bus_tx_enable;
			if (from_sleep || status_read) begin
				battery_fail_flag <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// file: tb/sbc_mode_chk_sva.sv
// Checker for the mode and interrupt controller.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_mode_cfg.svh"
module sbc_mode_chk
	import sbc_mode_pkg::*;
(
	// Clock and reset
	input wire logic                  clk,
	input wire logic                  reset,
	// Inputs watched
	input wire logic                  watchdog_config_grounded,
	input wire logic                  mode_write,
	input wire logic [1:0]            mode_select_bits,
	input wire logic                  status_read,
	input wire logic [`IRQ_SRC_W-1:0] fault_level,
	// Outputs watched
	input wire logic                  reset_out_low,
	input wire logic                  irq_low,
	input wire op_mode_t              mode,
	input wire mode_outputs_t         outs,
	input wire logic                  bus_driver_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	int unsigned held;
	wire logic   cmd = mode_write && mode == st_normal;
	wire logic   bus_fault = (fault_level & `IRQ_BUS_MASK) != 0;

	// Cycles spent in reset mode
	always_ff @(posedge clk)
		held <= (reset || mode != st_reset) ? 0 : held + 1;

	chk_reset_pin: assert property (
		mode == st_reset && !$past(reset) |-> !reset_out_low
		&& !outs.high_side_switch && outs.low_side_switches == 2'h0)
		else $error("reset pin or switches wrong in reset mode");
	chk_reset_exit: assert property (
		$past(mode) == st_reset && mode != st_reset |->
		held >= `RESET_HOLD_CYCLES - 2 && mode == (watchdog_config_grounded
		? st_normal : st_normal_req)) else $error("reset exit wrong");
	chk_nreq_outs: assert property (
		mode == st_normal_req |-> reset_out_low && outs.regulator_on
		&& outs.bus_rx_enable && !outs.bus_tx_enable)
		else $error("normal request outputs wrong");
	chk_normal_cmd: assert property (
		mode_write && mode_select_bits == `MODE_SEL_NORMAL &&
		mode == st_normal_req && watchdog_config_grounded
		|=> mode == st_normal) else $error("normal command not taken");
	chk_sleep_cmd: assert property (
		cmd && mode_select_bits == `MODE_SEL_SLEEP |=> mode == st_sleep
		&& !outs.regulator_on) else $error("sleep command not taken");
	chk_stop_cmd: assert property (
		cmd && mode_select_bits == `MODE_SEL_STOP |=> mode == st_stop
		&& outs.regulator_on && !outs.regulator_full)
		else $error("stop command not taken");
	chk_irq_ack: assert property (
		status_read && mode != st_stop && fault_level == 0
		&& $past(fault_level) == 0 && $past(fault_level, 2) == 0
		|=> irq_low) else $error("interrupt not released");
	chk_bus_off: assert property (
		bus_fault |-> ##4 !bus_driver_enable)
		else $error("bus driver on under fault");
endmodule
bind sbc_mode_and_irq_control sbc_mode_chk CHK (.clk, .reset,
	.watchdog_config_grounded, .mode_write, .mode_select_bits, .status_read,
	.fault_level, .reset_out_low, .irq_low, .mode, .outs, .bus_driver_enable);
`default_nettype wire

// file: tb/host_mcu.sv
// Host controller model: command pulses and acknowledge reads.
// Assumes the bench calls its tasks; outputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_mode_cfg.svh"
module host_mcu (
	// Clock
	input  wire logic  clk,
	// Command pulses
	output logic       mode_write,
	output logic [1:0] mode_select_bits,
	output logic       timing_write,
	output logic       status_read,
	output logic       wake_source_read
);
	logic [3:0] cmd = 4'h0;
	initial mode_select_bits = 2'h3;
	assign {mode_write, timing_write, status_read, wake_source_read} = cmd;
	// One-cycle pulse; select bits inverted when idle
	task automatic send(input logic [3:0] c, input logic [1:0] b);
		@(negedge clk);
		cmd = c;
		mode_select_bits = b;
		@(negedge clk);
		cmd = 4'h0;
		mode_select_bits = ~b;
	endtask
	task automatic ask_normal;
		send(4'h4, 2'h3);
		send(4'h8, `MODE_SEL_NORMAL);
	endtask
	task automatic ack;
		send(4'h2, 2'h3);
	endtask
	task automatic read_wake;
		send(4'h1, 2'h3);
	endtask
endmodule
`default_nettype wire

// file: tb/sbc_mode_and_irq_control_bench.sv
// Self-checking bench for the mode and interrupt controller.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_mode_cfg.svh"
module sbc_mode_and_irq_control_bench;
	import sbc_mode_pkg::*;
	logic          clk = 1'h0, reset = 1'h1, pwm_input_pin = 1'h0;
	logic          watchdog_config_grounded = 1'h1;
	logic          watchdog_config_open = 1'h0, regulator_low = 1'h0;
	logic          ext_reset_low = 1'h0, chip_select_rise = 1'h0;
	logic          wake_event = 1'h0, cyclic_tick = 1'h0;
	logic          watchdog_fail = 1'h0, watchdog_clear_early = 1'h0;
	logic [7:0]    fault_level = 8'h00, interrupt_mask_reg = 8'h00;
	switch_cfg_t   switch_cfg = 7'h00;
	wire logic     mode_write, timing_write, status_read, wake_source_read;
	wire logic     reset_out_low, irq_low, wake_pending;
	wire logic     battery_fail_flag, bus_driver_enable;
	wire logic [1:0] mode_select_bits;
	wire logic [7:0] interrupt_source_reg;
	wire op_mode_t mode;
	wire mode_outputs_t outs;
	int            bad_count = 0, n_compared = 0;

	sbc_mode_and_irq_control DUT (.clk, .reset, .watchdog_config_grounded,
		.watchdog_config_open, .regulator_low, .ext_reset_low, .pwm_input_pin,
		.chip_select_rise, .wake_event, .cyclic_tick, .fault_level, .mode_write,
		.mode_select_bits, .timing_write, .watchdog_fail, .watchdog_clear_early,
		.status_read, .wake_source_read, .interrupt_mask_reg, .switch_cfg,
		.reset_out_low, .irq_low, .mode, .outs, .interrupt_source_reg,
		.wake_pending, .battery_fail_flag, .bus_driver_enable);
	host_mcu HOST (.clk, .mode_write, .mode_select_bits, .timing_write,
		.status_read, .wake_source_read);

	always #2.5 clk = ~clk;

	task automatic expect_eq(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_mode(input op_mode_t m, input int lim);
		while (mode !== m && lim-- > 0)
			@(negedge clk);
		expect_eq("mode", m, mode);
	endtask
	task automatic give_verdict;
		$display("compared %0d, mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#2500000;
		bad_count++;
		give_verdict;
	end

	initial begin
		step(12);
		reset = 1'h0;
		step(100);
		expect_eq("reset pin", 0, reset_out_low);
		step(195000);
		expect_eq("mode", st_reset, mode);
		wait_mode(st_normal, 10000);
		expect_eq("reset pin", 1, reset_out_low);
		$display("test done: power-up");
		switch_cfg = 7'h40;
		step(5);
		expect_eq("high side", 1, outs.high_side_switch);
		switch_cfg = 7'h60;
		step(5);
		expect_eq("high side", 0, outs.high_side_switch);
		pwm_input_pin = 1'h1;
		step(5);
		expect_eq("high side", 1, outs.high_side_switch);
		$display("test done: switches");
		for (int i = 0; i < 8; i++) begin
			fault_level = 8'h01 << i;
			step(6);
			expect_eq("irq", 0, irq_low);
			expect_eq("source", fault_level, interrupt_source_reg);
			fault_level = 8'h00;
			step(6);
			expect_eq("bus drv", i < 3 || i > 5, bus_driver_enable);
			HOST.ack;
			step(2);
			expect_eq("irq", 1, irq_low);
			expect_eq("bus drv", 1, bus_driver_enable);
		end
		interrupt_mask_reg = 8'h01;
		fault_level = 8'h01;
		step(6);
		expect_eq("irq", 1, irq_low);
		fault_level = 8'h00;
		interrupt_mask_reg = 8'h00;
		step(4);
		HOST.ack;
		$display("test done: interrupts");
		HOST.send(4'h8, `MODE_SEL_STOP);
		expect_eq("mode", st_stop, mode);
		wake_event = 1'h1;
		step(1);
		wake_event = 1'h0;
		step(6);
		expect_eq("mode", st_normal, mode);
		expect_eq("irq", 0, irq_low);
		HOST.ack;
		fault_level = 8'h01;
		step(6);
		expect_eq("irq", 1, irq_low);
		HOST.read_wake;
		step(6);
		expect_eq("irq", 0, irq_low);
		fault_level = 8'h00;
		step(4);
		HOST.ack;
		HOST.ask_normal;
		expect_eq("mode", st_normal, mode);
		HOST.send(4'h8, `MODE_SEL_STOP);
		chip_select_rise = 1'h1;
		step(1);
		chip_select_rise = 1'h0;
		step(6);
		expect_eq("mode", st_normal, mode);
		expect_eq("irq", 1, irq_low);
		HOST.ask_normal;
		$display("test done: stop");
		HOST.send(4'h8, `MODE_SEL_SLEEP);
		expect_eq("mode", st_sleep, mode);
		expect_eq("regulator", 0, outs.regulator_on);
		wake_event = 1'h1;
		step(1);
		wake_event = 1'h0;
		step(6);
		expect_eq("mode", st_reset, mode);
		expect_eq("batt fail", 0, battery_fail_flag);
		watchdog_config_grounded = 1'h0;
		watchdog_config_open = 1'h1;
		wait_mode(st_normal_req, 210000);
		expect_eq("bus tx", 0, outs.bus_tx_enable);
		HOST.ask_normal;
		expect_eq("mode", st_normal_req, mode);
		$display("test done: sleep");
		give_verdict;
	end
endmodule
`default_nettype wire
